// [logic/hbp_host_byte_port.sv]
// host byte port: 8-bit host access to status and data registers
// Function
// RL1 - register select high connects the bus to the status register
// RL2 - select low: read returns outbound data, write loads inbound data
// RL3 - byte select high picks bits 15..8, low picks bits 7..0
// RL4 - data bus floats unless a host read is in progress
// RL5 - each transfer moves exactly one byte over the eight-bit path
// RL6 - host keeps select and address stable, one strobe at a time
`timescale 1ns/1ps
module hbp_host_byte_port
  import hbp_pkg::*;
(
  input  wire logic                  I_CORE_CLK,          // core clock
  input  wire logic                  I_RESET_N,           // async reset
  input  wire logic                  I_REG_SEL,           // register select
  input  wire logic                  I_BYTE_SEL,          // byte select
  input  wire logic                  I_CS_N,              // chip select
  input  wire logic                  I_RD_N,              // read strobe
  input  wire logic                  I_WR_N,              // write strobe
  input  wire logic [HBP_BYTE_W-1:0] I_HBUS,              // bus input
  output logic      [HBP_BYTE_W-1:0] O_HBUS,              // bus output
  output logic                       O_HBUS_OE,           // bus drive
  input  wire logic [HBP_REG_W-1:0]  I_STATUS,            // status word
  input  wire logic [HBP_REG_W-1:0]  I_OUT_DATA,          // outbound word
  output logic      [HBP_REG_W-1:0]  O_IN_DATA,           // inbound word
  output logic                       O_IN_VALID,          // byte valid
  output logic                       O_IN_HIGH,           // byte high half
  output logic      [HBP_BYTE_W-1:0] O_IN_BYTE,           // byte data
  input  wire logic                  I_IN_READY,          // core ready
  output logic                       O_WR_STALL           // buffer full
);

  // two-flop synchronisers for all host pins
  logic [4:0]            pin_s1_reg;
  logic [4:0]            pin_s2_reg;
  logic [HBP_BYTE_W-1:0] bus_s1_reg;
  logic [HBP_BYTE_W-1:0] bus_s2_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pin_s1_reg <= 5'h1F;
      pin_s2_reg <= 5'h1F;
      bus_s1_reg <= HBP_BYTE_RST;
      bus_s2_reg <= HBP_BYTE_RST;
    end else begin
      pin_s1_reg <= {I_CS_N, I_RD_N, I_WR_N, I_REG_SEL, I_BYTE_SEL};
      pin_s2_reg <= pin_s1_reg;
      bus_s1_reg <= I_HBUS;
      bus_s2_reg <= bus_s1_reg;
    end
  end

  // decoded synchronised strobes
  wire cs_n     = pin_s2_reg[4];
  wire rd_n     = pin_s2_reg[3];
  wire wr_n     = pin_s2_reg[2];
  wire reg_sel  = pin_s2_reg[1];
  wire byte_sel = pin_s2_reg[0];
  wire rd_act   = !cs_n && !rd_n && wr_n;
  wire wr_act   = !cs_n && !wr_n && rd_n;

  // access phase tracking
  hbp_phase_e phase_reg;
  hbp_phase_e phase_next;
  always_comb begin
    phase_next = HBP_IDLE;
    case ({rd_act, wr_act})
      2'b10:   phase_next = HBP_READ;
      2'b01:   phase_next = HBP_WRITE;
      default: phase_next = HBP_IDLE;
    endcase
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) phase_reg <= HBP_IDLE;
    else            phase_reg <= phase_next;
  end
  wire wr_start = (phase_next == HBP_WRITE) && (phase_reg != HBP_WRITE);

  // RL1 RL2 read source: status or outbound data
  wire [HBP_REG_W-1:0] rd_word =
    (reg_sel == HBP_SEL_STATUS) ? I_STATUS : I_OUT_DATA;
  // RL3 RL5 byte half of the selected word
  wire [HBP_BYTE_W-1:0] rd_byte = (byte_sel == HBP_SEL_HIGH)
    ? rd_word[HBP_HI_MSB:HBP_HI_LSB] : rd_word[HBP_LO_MSB:HBP_LO_LSB];

  // RL4 bus drive only during a read
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_HBUS    <= HBP_BYTE_RST;
      O_HBUS_OE <= 1'b0;
    end else begin
      O_HBUS    <= rd_byte;
      O_HBUS_OE <= (phase_next == HBP_READ);
    end
  end

  // read side checks: drive window and returned byte
  // RL4 no drive outside read
  bus_float_a: assert property ( // RL4
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    O_HBUS_OE |-> $past(rd_act))
    else $error("bus driven outside read");

  // RL4 read drives bus
  read_drive_a: assert property ( // RL4
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act |=> O_HBUS_OE)
    else $error("read not driven");

  // RL4 write keeps bus off
  write_float_a: assert property ( // RL4
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    wr_act |=> !O_HBUS_OE)
    else $error("bus driven during write");

  // RL1 status low byte
  status_read_a: assert property ( // RL1
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act && reg_sel == HBP_SEL_STATUS && byte_sel != HBP_SEL_HIGH
    |=> O_HBUS == $past(I_STATUS[HBP_LO_MSB:HBP_LO_LSB]))
    else $error("bad status byte");

  // RL3 status high byte
  status_high_a: assert property ( // RL3
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act && reg_sel == HBP_SEL_STATUS && byte_sel == HBP_SEL_HIGH
    |=> O_HBUS == $past(I_STATUS[HBP_HI_MSB:HBP_HI_LSB]))
    else $error("bad status high byte");

  // RL2 outbound high byte
  outbound_read_a: assert property ( // RL2
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act && reg_sel != HBP_SEL_STATUS && byte_sel == HBP_SEL_HIGH
    |=> O_HBUS == $past(I_OUT_DATA[HBP_HI_MSB:HBP_HI_LSB]))
    else $error("bad outbound byte");

  // RL3 outbound low byte
  outbound_low_a: assert property ( // RL3
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act && reg_sel != HBP_SEL_STATUS && byte_sel != HBP_SEL_HIGH
    |=> O_HBUS == $past(I_OUT_DATA[HBP_LO_MSB:HBP_LO_LSB]))
    else $error("bad outbound low byte");

  // two-entry buffer between host writes and inbound register
  hbp_byte_s buf_mem [2];
  logic      wp_reg;
  logic      rp_reg;
  logic [1:0] cnt_reg;
  wire        buf_full  = (cnt_reg == 2'h2);
  wire        buf_empty = (cnt_reg == 2'h0);
  // RL2 write to data register when select low
  wire        push = wr_start && (reg_sel != HBP_SEL_STATUS) && !buf_full;
  wire        pop  = !buf_empty && I_IN_READY;
  hbp_byte_s  push_item;
  assign push_item.high_half = (byte_sel == HBP_SEL_HIGH);
  assign push_item.data      = bus_s2_reg;
  assign O_IN_VALID = !buf_empty;
  assign O_IN_HIGH  = buf_mem[rp_reg].high_half;
  assign O_IN_BYTE  = buf_mem[rp_reg].data;
  assign O_WR_STALL = buf_full;

  // buffer pointers and storage
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (push) buf_mem[wp_reg] <= push_item;
      if (push) wp_reg <= !wp_reg;
      if (pop)  rp_reg <= !rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // write side checks: queueing, dropping, bounds
  // RL2 data write queues
  write_queue_a: assert property ( // RL2
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    wr_start && reg_sel != HBP_SEL_STATUS && buf_empty
    |=> O_IN_VALID && O_IN_BYTE == $past(bus_s2_reg))
    else $error("lost write");

  // RL1 status write dropped
  status_write_a: assert property ( // RL1
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    wr_start && reg_sel == HBP_SEL_STATUS && buf_empty && !I_IN_READY
    |=> !O_IN_VALID)
    else $error("status write queued");

  // RL5 full buffer keeps head
  full_drop_a: assert property ( // RL5
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    wr_start && reg_sel != HBP_SEL_STATUS && buf_full && !I_IN_READY
    |=> O_WR_STALL && O_IN_BYTE == $past(O_IN_BYTE))
    else $error("full buffer overwritten");

  // RL5 buffer never overflows
  buf_bound_a: assert property ( // RL5
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    cnt_reg <= 2'h2)
    else $error("buffer overflow");

  // RL3 inbound register half update on drain
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_IN_DATA <= HBP_DATA_RST;
    end else if (pop) begin
      if (O_IN_HIGH) O_IN_DATA[HBP_HI_MSB:HBP_HI_LSB] <= O_IN_BYTE;
      else           O_IN_DATA[HBP_LO_MSB:HBP_LO_LSB] <= O_IN_BYTE;
    end
  end

  // drain checks: popped byte lands in its half
  // RL3 high half lands
  high_land_a: assert property ( // RL3
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    pop && O_IN_HIGH
    |=> O_IN_DATA[HBP_HI_MSB:HBP_HI_LSB] == $past(O_IN_BYTE))
    else $error("bad high half");

  // RL3 low half lands
  low_land_a: assert property ( // RL3
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    pop && !O_IN_HIGH
    |=> O_IN_DATA[HBP_LO_MSB:HBP_LO_LSB] == $past(O_IN_BYTE))
    else $error("bad low half");

  // main scenarios: read, status read, queued write, full, dropped write
  cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) rd_act);
  cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) push);
  cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) buf_full);
  cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rd_act && reg_sel == HBP_SEL_STATUS);
  cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    wr_start && buf_full);
endmodule

// [logic/hbp_pkg.sv]
// package: constants and carrier types for the host byte port
package hbp_pkg;
  localparam int HBP_BYTE_W = 8;
  localparam int HBP_REG_W  = 16;
  localparam int HBP_HI_MSB = 15;
  localparam int HBP_HI_LSB = 8;
  localparam int HBP_LO_MSB = 7;
  localparam int HBP_LO_LSB = 0;
  localparam logic HBP_SEL_STATUS = 1'h1;
  localparam logic HBP_SEL_HIGH   = 1'h1;
  localparam logic [15:0] HBP_DATA_RST = 16'h0000;
  localparam logic [7:0]  HBP_BYTE_RST = 8'h00;

  // access phase of the host strobes
  typedef enum logic [1:0] {
    HBP_IDLE  = 2'b00,
    HBP_READ  = 2'b01,
    HBP_WRITE = 2'b10
  } hbp_phase_e;

  // one inbound byte as it leaves the port
  typedef struct packed {
    logic                  high_half;
    logic [HBP_BYTE_W-1:0] data;
  } hbp_byte_s;
endpackage

// [tb/hbp_host_model.sv]
// host model: drives the host pins and resolves the byte bus
`timescale 1ns/1ps
module hbp_host_model (
  input  wire logic       i_clk,  // core clock
  input  wire logic [7:0] i_dev,  // device byte
  input  wire logic       i_oe,   // device drives
  output logic      [7:0] o_bus,  // resolved bus
  output logic      [4:0] o_pins  // reg,byte,cs_n,rd_n,wr_n
);
  logic [7:0] drv;
  logic       wr_on;
  // bus level: device, host, else pull-up
  assign o_bus = i_oe ? i_dev : (wr_on ? drv : 8'hFF);
  // idle pins at start
  initial begin
    o_pins = 5'h07;
    wr_on = 1'b0;
    drv = 8'h00;
  end
  // one byte, one strobe, pins held 4 clocks
  task automatic access(input logic r, b, w, input logic [7:0] d,
                        output logic [7:0] q);
    {o_pins, drv, wr_on} = {r, b, 1'b0, w, !w, d, w};
    repeat (4) @(posedge i_clk);
    q = o_bus;
    #1 o_pins = 5'h07;
    wr_on = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
endmodule

// [tb/tb_hbp_host_byte_port.sv]
// testbench: host byte port driven by the model host
`timescale 1ns/1ps
module tb_hbp_host_byte_port;
  import hbp_pkg::*;
  logic        clk = 0, rst_n = 0, ready = 0, oe, valid, high, stall;
  logic [15:0] stat = 16'hA55A, outw = 16'h3CC3, in_data;
  logic [7:0]  bus, dev, q, in_byte;
  logic [4:0]  pins;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  hbp_host_byte_port hbp_host_byte_port_inst (.I_CORE_CLK(clk),
    .I_RESET_N(rst_n), .I_REG_SEL(pins[4]), .I_BYTE_SEL(pins[3]),
    .I_CS_N(pins[2]), .I_RD_N(pins[1]), .I_WR_N(pins[0]), .I_HBUS(bus),
    .O_HBUS(dev), .O_HBUS_OE(oe), .I_STATUS(stat), .I_OUT_DATA(outw),
    .O_IN_DATA(in_data), .O_IN_VALID(valid), .O_IN_HIGH(high),
    .O_IN_BYTE(in_byte), .I_IN_READY(ready), .O_WR_STALL(stall));
  hbp_host_model hbp_host_model_inst (.i_clk(clk), .i_dev(dev),
    .i_oe(oe), .o_bus(bus), .o_pins(pins));
  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // every register and half read, bus floats after
  task automatic read_all;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = i[1] ? stat : outw;
      hbp_host_model_inst.access(i[1], i[0], 1'b0, 8'h00, q);
      check(16'(q), 16'(i[0] ? w[15:8] : w[7:0]));
      check(16'(oe), 16'h0000);
    end
  endtask
  // data writes land in the chosen half
  task automatic write_data;
    ready = 1'b1;
    hbp_host_model_inst.access(1'b0, 1'b1, 1'b1, 8'h12, q);
    check(16'(oe), 16'h0000);
    hbp_host_model_inst.access(1'b0, 1'b0, 1'b1, 8'h34, q);
    check(in_data, 16'h1234);
  endtask
  // status write dropped, full buffer stalls and drops the third byte, drain delivers both queued bytes
  task automatic write_stall;
    ready = 1'b0;
    hbp_host_model_inst.access(1'b1, 1'b0, 1'b1, 8'hEE, q);
    check(16'(valid), 16'h0000);
    for (int i = 1; i < 4; i++)
      hbp_host_model_inst.access(1'b0, 1'b0, 1'b1, 8'(i), q);
    check({stall, valid, high, 5'h00, in_byte}, 16'hC001);
    ready = 1'b1;
    repeat (3) @(posedge clk);
    #1 check(in_data, 16'h1202);
    check(16'(valid), 16'h0000);
  endtask
  // high byte queued, mid-run reset clears it, port works after release
  task automatic reset_mid;
    ready = 1'b0;
    hbp_host_model_inst.access(1'b0, 1'b1, 1'b1, 8'h5A, q);
    check({stall, valid, high, 5'h00, in_byte}, 16'h605A);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(16'(valid), 16'h0000);
    check(16'(stall), 16'h0000);
    check(16'(oe), 16'h0000);
    check(in_data, 16'h0000);
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(16'(valid), 16'h0000);
    check(16'(oe), 16'h0000);
    hbp_host_model_inst.access(1'b1, 1'b1, 1'b0, 8'h00, q);
    check(16'(q), 16'(stat[15:8]));
    check(16'(oe), 16'h0000);
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    read_all();
    write_data();
    write_stall();
    reset_mid();
    conclude();
  end
endmodule
